// ### config_host.sv
/*
 host model: single-byte I/O cycles on the configuration register port.
 assumes the bench clock; strobes last one cycle, read answer within 3 edges.
*/
`timescale 1ns/1ps
module config_host
(
   input wire logic clk,
   output logic [15:0] io_addr,
   output logic [7:0] io_wdata,
   output logic io_wr,
   output logic io_rd,
   input wire logic [7:0] io_rdata,
   input wire logic io_rvalid
);
   initial
   begin
      io_addr = 16'hFFFF;
      io_wdata = 8'hFF;
      io_wr = 1'b0;
      io_rd = 1'b0;
   end
   // ==========================================================
   // bus cycles
   // index before data
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      io_addr <= a;
      io_wdata <= d;
      io_wr <= 1'b1;
      @(posedge clk);
      io_wr <= 1'b0;
      // released lines show the inverse so a stale value cannot pass
      io_addr <= ~a;
      io_wdata <= ~d;
   endtask : wr
   task automatic rd(input logic [15:0] a, output logic [7:0] d, output bit ok);
      ok = 1'b0;
      d = 8'h00;
      @(posedge clk);
      io_addr <= a;
      io_rd <= 1'b1;
      @(posedge clk);
      io_rd <= 1'b0;
      io_addr <= ~a;
      for (int n = 0; n < 3; n++)
      begin
         #1;
         if (!ok && io_rvalid === 1'b1)
         begin
            ok = 1'b1;
            d = io_rdata;
         end
         @(posedge clk);
      end
   endtask : rd
endmodule : config_host

// ### global_config_pkg.sv
/*
 global configuration register bank: index map, field positions, masks,
 reset values and strap defaults. assumes 8-bit index and data ports.
*/
package global_config_pkg;
   // ==========================================================
   // index map
   localparam logic [7:0] IDX_CONFIG_CONTROL = 8'h02;
   localparam logic [7:0] IDX_LOGICAL_DEVICE_SELECT = 8'h07;
   localparam logic [7:0] IDX_DEVICE_IDENTIFICATION = 8'h20;
   localparam logic [7:0] IDX_DEVICE_REVISION = 8'h21;
   localparam logic [7:0] IDX_FUNCTION_POWER_CONTROL = 8'h22;
   localparam logic [7:0] IDX_RESERVED_SCRATCH = 8'h23;
   localparam logic [7:0] IDX_CLOCK_SOURCE_CONTROL = 8'h24;
   localparam logic [7:0] IDX_CONFIG_PORT_ADDR_LOW = 8'h26;
   localparam logic [7:0] IDX_CONFIG_PORT_ADDR_HIGH = 8'h27;
   localparam logic [7:0] IDX_RESERVED_ZERO = 8'h28;
   localparam logic [7:0] IDX_GLOBAL_LAST = 8'h2F;
   localparam logic [7:0] IDX_ACTIVATE = 8'h30;
   // ==========================================================
   // fields
   localparam int SOFT_RESET_BIT = 0;
   localparam int PWR_FLOPPY_BIT = 0;
   localparam int PWR_PARALLEL_BIT = 3;
   localparam int PWR_SERIAL1_BIT = 4;
   localparam int PWR_SERIAL2_BIT = 5;
   localparam int PLL_OFF_BIT = 1;
   localparam int CLK_STATE_LSB = 2;
   localparam int ADDR_QUAL16_BIT = 6;
   localparam int ACTIVATE_BIT = 0;
   localparam logic [1:0] CLK_STATE_STOP = 2'h3;
   localparam logic [7:0] FUNCTION_POWER_MASK = 8'h39;
   localparam logic [7:0] CLOCK_SOURCE_MASK = 8'h4E;
   localparam logic [7:0] ADDR_LOW_MASK = 8'hFE;
   localparam int QUAL12_WIDTH = 12;
   localparam int LDEV_COUNT = 16;
   localparam int LDEV_SEL_WIDTH = 4;
   // ==========================================================
   // reset values
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_CLOCK_SOURCE_CONTROL = 8'h44;
   localparam logic [15:0] RST_CONFIG_PORT_ADDR = 16'h0000;
   localparam logic [15:0] STRAP_ADDR_00 = 16'h162E;
   localparam logic [15:0] STRAP_ADDR_01 = 16'h164E;
   localparam logic [15:0] STRAP_ADDR_10 = 16'h002E;
   localparam logic [15:0] STRAP_ADDR_11 = 16'h004E;
   localparam logic [7:0] DEVICE_REVISION_VALUE = 8'h01;
   localparam logic [1:0] INIT_DONE_COUNT = 2'h3;
endpackage : global_config_pkg

// ### global_config_register_bank.sv
/*
 global configuration register bank reached by an index port and a data
 port at a relocatable I/O address. assumes io_* strobes are one-cycle
 pulses on clk from the host bus decoder; reset pins and straps are async.
*/
`timescale 1ns/1ps
module global_config_register_bank
   import global_config_pkg::*;
#(
   // arbitrary value, not tied to any real part
   parameter logic [7:0] DEVICE_IDENTIFICATION_VALUE = 8'hA5
)
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic bus_reset_b,
   input wire logic main_por_b,
   input wire logic [1:0] strap_option_pair,
   input wire logic config_mode,
   input wire logic [15:0] io_addr,
   input wire logic [7:0] io_wdata,
   input wire logic io_wr,
   input wire logic io_rd,
   output logic [7:0] io_rdata,
   output logic io_rvalid,
   output logic soft_reset_pulse,
   output logic [7:0] logical_device_sel,
   output logic [LDEV_COUNT-1:0] device_active,
   output logic floppy_controller_power,
   output logic parallel_power,
   output logic serial1_power,
   output logic serial2_power,
   output logic pll_off,
   output logic osc_stop,
   output logic baud_clock_generator_en,
   output logic addr_qual_16,
   output logic [15:0] config_port_addr
);
   // ==========================================================
   // decode helpers
   function automatic logic port_match(input logic [15:0] a, input logic [15:0] base,
                                       input logic q16);
      // 12-bit compare is the legacy mode; upper nibble is then don't care
      if (q16)
         port_match = (a == base);
      else
         port_match = (a[QUAL12_WIDTH-1:0] == base[QUAL12_WIDTH-1:0]);
   endfunction : port_match

   function automatic logic [15:0] strap_default(input logic [1:0] s);
      case (s)
         2'h0: strap_default = STRAP_ADDR_00;
         2'h1: strap_default = STRAP_ADDR_01;
         2'h2: strap_default = STRAP_ADDR_10;
         default: strap_default = STRAP_ADDR_11;
      endcase
   endfunction : strap_default

   // ==========================================================
   // synchronisers and hard reset
   logic bus_s1_reg, bus_s2_reg, por_s1_reg, por_s2_reg;
   logic [1:0] strap_s1_reg, strap_s2_reg;
   logic [1:0] init_cnt_reg;
   logic hard_rst;

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         bus_s1_reg <= 1'b0;
         bus_s2_reg <= 1'b0;
         por_s1_reg <= 1'b0;
         por_s2_reg <= 1'b0;
         strap_s1_reg <= 2'h0;
         strap_s2_reg <= 2'h0;
      end
      else
      begin
         bus_s1_reg <= bus_reset_b;
         bus_s2_reg <= bus_s1_reg;
         por_s1_reg <= main_por_b;
         por_s2_reg <= por_s1_reg;
         strap_s1_reg <= strap_option_pair;
         strap_s2_reg <= strap_s1_reg;
      end
   end

   // hold hard reset until the strap synchroniser has settled
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         init_cnt_reg <= 2'h0;
      else if (init_cnt_reg != INIT_DONE_COUNT)
         init_cnt_reg <= init_cnt_reg + 2'h1;
   end

   assign hard_rst = !bus_s2_reg || !por_s2_reg || (init_cnt_reg != INIT_DONE_COUNT);

   // ==========================================================
   // port decode
   logic [7:0] index_reg;
   logic [7:0] addr_low_reg;
   logic [7:0] power_reg, scratch_reg, osc_reg, ldev_reg;
   logic [LDEV_COUNT-1:0] active_reg;
   logic soft_reg;
   logic idx_hit, dat_hit, idx_wr, dat_wr;

   // index at base, data at the next byte
   assign idx_hit = config_mode && port_match(io_addr, config_port_addr, addr_qual_16);
   assign dat_hit = config_mode &&
      port_match(io_addr, {config_port_addr[15:1], 1'b1}, addr_qual_16);
   assign idx_wr = io_wr && idx_hit;
   assign dat_wr = io_wr && dat_hit;

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         index_reg <= RST_ZERO;
      else if (hard_rst)
         index_reg <= RST_ZERO;
      else if (idx_wr)
         index_reg <= io_wdata;
   end

   // ==========================================================
   // soft reset
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         soft_reg <= 1'b0;
      else if (hard_rst)
         soft_reg <= 1'b0;
      else
         soft_reg <= dat_wr && (index_reg == IDX_CONFIG_CONTROL) && io_wdata[SOFT_RESET_BIT];
   end
   assign soft_reset_pulse = soft_reg;

   // ==========================================================
   // soft-resettable registers
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ldev_reg <= RST_ZERO;
         power_reg <= RST_ZERO;
      end
      // device select cleared on every reset
      else if (hard_rst || soft_reg)
      begin
         ldev_reg <= RST_ZERO;
         power_reg <= RST_ZERO;
      end
      // data write routed by the held index
      else if (dat_wr)
      begin
         if (index_reg == IDX_LOGICAL_DEVICE_SELECT)
            ldev_reg <= io_wdata;
         // only the four enables are stored
         if (index_reg == IDX_FUNCTION_POWER_CONTROL)
            power_reg <= io_wdata & FUNCTION_POWER_MASK;
      end
   end

   genvar g;
   generate
      for (g = 0; g < LDEV_COUNT; g++)
      begin : g_act
         always_ff @(posedge clk or negedge rst_b)
         begin
            if (!rst_b)
               active_reg[g] <= 1'b0;
            else if (hard_rst || soft_reg)
               active_reg[g] <= 1'b0;
            else if (dat_wr && index_reg == IDX_ACTIVATE && ldev_reg == 8'(g))
               active_reg[g] <= io_wdata[ACTIVATE_BIT];
         end
      end
   endgenerate

   // ==========================================================
   // hard-reset-only registers
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         scratch_reg <= RST_ZERO;
         osc_reg <= RST_CLOCK_SOURCE_CONTROL;
      end
      // oscillator default on hard resets, soft reset ignored
      else if (hard_rst)
      begin
         scratch_reg <= RST_ZERO;
         osc_reg <= RST_CLOCK_SOURCE_CONTROL;
      end
      else if (dat_wr)
      begin
         if (index_reg == IDX_RESERVED_SCRATCH)
            scratch_reg <= io_wdata;
         if (index_reg == IDX_CLOCK_SOURCE_CONTROL)
            osc_reg <= io_wdata & CLOCK_SOURCE_MASK;
      end
   end

   // ==========================================================
   // configuration port address
   logic [15:0] port_reg;
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         port_reg <= RST_CONFIG_PORT_ADDR;
         addr_low_reg <= RST_ZERO;
      end
      // strap default returns only on hard_rst: bus reset, main-supply reset, or the init count after rst_b
      else if (hard_rst)
      begin
         port_reg <= strap_default(strap_s2_reg);
         addr_low_reg <= 8'(strap_default(strap_s2_reg)) & ADDR_LOW_MASK;
      end
      else if (dat_wr)
      begin
         // low byte staged, bit 0 forced zero
         if (index_reg == IDX_CONFIG_PORT_ADDR_LOW)
            addr_low_reg <= io_wdata & ADDR_LOW_MASK;
         // port moves on the high byte write
         if (index_reg == IDX_CONFIG_PORT_ADDR_HIGH)
            port_reg <= {io_wdata, addr_low_reg};
      end
   end
   assign config_port_addr = port_reg;

   // ==========================================================
   // read path
   function automatic logic [7:0] read_mux(input logic [7:0] idx);
      case (idx)
         IDX_LOGICAL_DEVICE_SELECT: read_mux = ldev_reg;
         IDX_DEVICE_IDENTIFICATION: read_mux = DEVICE_IDENTIFICATION_VALUE;
         IDX_DEVICE_REVISION: read_mux = DEVICE_REVISION_VALUE;
         IDX_FUNCTION_POWER_CONTROL: read_mux = power_reg;
         IDX_RESERVED_SCRATCH: read_mux = scratch_reg;
         IDX_CLOCK_SOURCE_CONTROL: read_mux = osc_reg;
         IDX_CONFIG_PORT_ADDR_LOW: read_mux = addr_low_reg;
         IDX_CONFIG_PORT_ADDR_HIGH: read_mux = port_reg[15:8];
         IDX_ACTIVATE: read_mux = {7'h00, active_reg[ldev_reg[LDEV_SEL_WIDTH-1:0]]
            & (ldev_reg < 8'(LDEV_COUNT))};
         // write-only, reserved-zero and unused indexes read zero
         default: read_mux = RST_ZERO;
      endcase
   endfunction : read_mux

   logic [7:0] rdata_reg;
   logic rvalid_reg;
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rdata_reg <= RST_ZERO;
         rvalid_reg <= 1'b0;
      end
      else
      begin
         rvalid_reg <= io_rd && (idx_hit || dat_hit);
         if (io_rd && idx_hit)
            rdata_reg <= index_reg;
         // data read routed by the held index
         else if (io_rd && dat_hit)
            rdata_reg <= read_mux(index_reg);
         else
            rdata_reg <= RST_ZERO;
      end
   end
   assign io_rdata = rdata_reg;
   assign io_rvalid = rvalid_reg;

   // ==========================================================
   // outputs; decoded bits are registered so every pin except baud_clock_generator_en, an inverted stop_reg, leaves a flop
   logic stop_reg, pll_reg, q16_reg;
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         stop_reg <= 1'b0;
         pll_reg <= 1'b0;
         q16_reg <= RST_CLOCK_SOURCE_CONTROL[ADDR_QUAL16_BIT];
      end
      else
      begin
         // 11 stops oscillator and baud clock
         stop_reg <= (osc_reg[CLK_STATE_LSB+1:CLK_STATE_LSB] == CLK_STATE_STOP);
         pll_reg <= osc_reg[PLL_OFF_BIT];
         q16_reg <= osc_reg[ADDR_QUAL16_BIT];
      end
   end
   assign osc_stop = stop_reg;
   assign baud_clock_generator_en = !stop_reg;
   assign pll_off = pll_reg;
   assign addr_qual_16 = q16_reg;
   assign logical_device_sel = ldev_reg;
   assign device_active = active_reg;
   assign floppy_controller_power = power_reg[PWR_FLOPPY_BIT];
   assign parallel_power = power_reg[PWR_PARALLEL_BIT];
   assign serial1_power = power_reg[PWR_SERIAL1_BIT];
   assign serial2_power = power_reg[PWR_SERIAL2_BIT];

   // ==========================================================
   // checks
   a_soft_one_cycle:
   assert property (@(posedge clk) disable iff (!rst_b) soft_reg |=> !soft_reg)
      else $error("soft reset pulse longer than one cycle");

   a_soft_clears_ldev:
   assert property (@(posedge clk) disable iff (!rst_b)
      soft_reg && !hard_rst |=> ldev_reg == RST_ZERO && active_reg == '0)
      else $error("soft reset left device select or activate set");

   a_read_latency:
   assert property (@(posedge clk) disable iff (!rst_b)
      io_rd && dat_hit && index_reg == IDX_DEVICE_IDENTIFICATION && !hard_rst
      |=> io_rvalid && io_rdata == DEVICE_IDENTIFICATION_VALUE)
      else $error("identification read wrong or late");

   a_port_even:
   assert property (@(posedge clk) disable iff (!rst_b) !port_reg[0] && !addr_low_reg[0])
      else $error("configuration address odd");

   a_osc_stop_follow:
   assert property (@(posedge clk) disable iff (!rst_b)
      ##1 osc_stop == ($past(osc_reg[3:2]) == CLK_STATE_STOP))
      else $error("oscillator stop does not follow clock state");

   a_mode_gate:
   assert property (@(posedge clk) disable iff (!rst_b)
      !config_mode && !hard_rst && !soft_reg |=> $stable(power_reg) && $stable(index_reg))
      else $error("register changed outside configuration mode");

   a_relocate_now:
   assert property (@(posedge clk) disable iff (!rst_b)
      dat_wr && !hard_rst && index_reg == IDX_CONFIG_PORT_ADDR_HIGH
      |=> port_reg == {$past(io_wdata), $past(addr_low_reg)})
      else $error("port did not move on high byte write");

   a_osc_soft_keep:
   assert property (@(posedge clk) disable iff (!rst_b)
      soft_reg && !hard_rst && !dat_wr |=> $stable(osc_reg) && $stable(port_reg))
      else $error("soft reset changed oscillator or port address");

   a_unused_zero:
   assert property (@(posedge clk) disable iff (!rst_b)
      io_rd && dat_hit && !idx_hit && index_reg == IDX_RESERVED_ZERO |=> io_rdata == RST_ZERO)
      else $error("reserved index read nonzero");
endmodule : global_config_register_bank

// ### test_global_config_register_bank.sv
/*
 testbench for the global configuration register bank.
 assumes config_host drives the I/O strobes; the bench drives resets and mode.
*/
`timescale 1ns/1ps
module test_global_config_register_bank
   import global_config_pkg::*;
;
   // arbitrary value, not tied to any real part
   localparam logic [7:0] TB_ID = 8'h5A;
   logic clk, rst_b, bus_reset_b, main_por_b, config_mode;
   logic [1:0] strap_option_pair;
   logic [15:0] io_addr, config_port_addr, device_active, base, old;
   logic [7:0] io_wdata, io_rdata, logical_device_sel;
   logic io_wr, io_rd, io_rvalid, soft_reset_pulse, pll_off, osc_stop, addr_qual_16;
   logic floppy_controller_power, parallel_power, serial1_power, serial2_power;
   logic baud_clock_generator_en;
   int error_cnt = 0;
   int checked = 0;
   int cycles = 0;
   int pulses;
   logic [7:0] held_d;
   bit held_ok;
   logic [7:0] holes [8] = '{8'h00, 8'h01, 8'h03, 8'h08, 8'h1F, 8'h25, 8'h28, 8'h2F};
   logic [15:0] strap_addr [4] = '{STRAP_ADDR_00, STRAP_ADDR_01, STRAP_ADDR_10, STRAP_ADDR_11};

   global_config_register_bank #(.DEVICE_IDENTIFICATION_VALUE(TB_ID)) u_global_config_register_bank (
      .clk(clk), .rst_b(rst_b), .bus_reset_b(bus_reset_b), .main_por_b(main_por_b),
      .strap_option_pair(strap_option_pair), .config_mode(config_mode),
      .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd),
      .io_rdata(io_rdata), .io_rvalid(io_rvalid), .soft_reset_pulse(soft_reset_pulse),
      .logical_device_sel(logical_device_sel), .device_active(device_active),
      .floppy_controller_power(floppy_controller_power), .parallel_power(parallel_power),
      .serial1_power(serial1_power), .serial2_power(serial2_power), .pll_off(pll_off),
      .osc_stop(osc_stop), .baud_clock_generator_en(baud_clock_generator_en),
      .addr_qual_16(addr_qual_16), .config_port_addr(config_port_addr));
   config_host u_config_host (.clk(clk), .io_addr(io_addr), .io_wdata(io_wdata),
      .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata), .io_rvalid(io_rvalid));

   // ==========================================================
   // clock and watchdog
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         error_cnt++;
         $display("ERROR %0t: timeout", $time);
         results();
      end
   end
   // ==========================================================
   // helpers
   task automatic results();
      $display("errors %0d checks %0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : results
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic reg_wr(input logic [7:0] idx, input logic [7:0] d);
      u_config_host.wr(base, idx);
      u_config_host.wr(base | 16'h0001, d);
   endtask : reg_wr
   task automatic reg_rd(input logic [7:0] idx, input logic [7:0] exp);
      logic [7:0] d;
      bit ok;
      u_config_host.wr(base, idx);
      u_config_host.rd(base | 16'h0001, d, ok);
      check({7'h00, ok, d}, {8'h01, exp});
   endtask : reg_rd
   task automatic rd_none(input logic [15:0] a);
      logic [7:0] d;
      bit ok;
      u_config_host.rd(a, d, ok);
      check({15'h0000, ok}, 16'h0000);
   endtask : rd_none
   task automatic settle();
      repeat (2) @(posedge clk);
      #1;
   endtask : settle
   task automatic bus_reset(input logic [1:0] s);
      @(posedge clk);
      strap_option_pair <= s;
      @(posedge clk);
      // odd straps pulse the bus reset, even ones the main-supply power-on reset
      if (s[0])
         bus_reset_b <= 1'b0;
      else
         main_por_b <= 1'b0;
      repeat (4) @(posedge clk);
      bus_reset_b <= 1'b1;
      main_por_b <= 1'b1;
      repeat (8) @(posedge clk);
      #1;
   endtask : bus_reset
   // ==========================================================
   // main sequence
   initial
   begin
      rst_b = 1'b0;
      bus_reset_b = 1'b0;
      main_por_b = 1'b0;
      config_mode = 1'b0;
      strap_option_pair = 2'h0;
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      bus_reset_b <= 1'b1;
      main_por_b <= 1'b1;
      config_mode <= 1'b1;
      repeat (6) @(posedge clk);
      #1;
      base = STRAP_ADDR_00;
      check(config_port_addr, STRAP_ADDR_00);
      check({13'h0000, addr_qual_16, osc_stop, pll_off}, 16'h0004);
      reg_rd(IDX_CLOCK_SOURCE_CONTROL, 8'h44);
      reg_rd(IDX_DEVICE_IDENTIFICATION, TB_ID);
      reg_rd(IDX_DEVICE_REVISION, DEVICE_REVISION_VALUE);
      reg_wr(IDX_DEVICE_IDENTIFICATION, 8'h00);
      reg_wr(IDX_DEVICE_REVISION, 8'h00);
      reg_rd(IDX_DEVICE_IDENTIFICATION, TB_ID);
      reg_rd(IDX_DEVICE_REVISION, DEVICE_REVISION_VALUE);
      foreach (holes[i])
      begin
         reg_wr(holes[i], 8'hFF);
         reg_rd(holes[i], 8'h00);
      end
      reg_wr(IDX_RESERVED_SCRATCH, 8'hC3);
      reg_rd(8'hA3, 8'h00);
      reg_rd(IDX_RESERVED_SCRATCH, 8'hC3);
      u_config_host.rd(base | 16'h0001, held_d, held_ok);
      check({7'h00, held_ok, held_d}, {8'h01, 8'hC3});
      reg_wr(IDX_FUNCTION_POWER_CONTROL, 8'hFF);
      reg_rd(IDX_FUNCTION_POWER_CONTROL, 8'h39);
      check({serial2_power, serial1_power, parallel_power, floppy_controller_power}, 16'h000F);
      reg_wr(IDX_FUNCTION_POWER_CONTROL, 8'h08);
      #1;
      check({serial2_power, serial1_power, parallel_power, floppy_controller_power}, 16'h0002);
      for (int s = 0; s < 4; s++)
      begin
         reg_wr(IDX_CLOCK_SOURCE_CONTROL, 8'hF2 | 8'(s << 2));
         settle();
         check({pll_off, osc_stop, baud_clock_generator_en}, {1'b1, s == 3, s != 3});
         reg_rd(IDX_CLOCK_SOURCE_CONTROL, 8'h42 | 8'(s << 2));
      end
      reg_wr(IDX_CLOCK_SOURCE_CONTROL, 8'h04);
      settle();
      check({15'h0000, addr_qual_16}, 16'h0000);
      old = base;
      base = base ^ 16'hF000;
      reg_rd(IDX_CLOCK_SOURCE_CONTROL, 8'h04);
      reg_wr(IDX_CLOCK_SOURCE_CONTROL, 8'h44);
      base = old;
      settle();
      rd_none(base ^ 16'hF001);
      config_mode <= 1'b0;
      reg_wr(IDX_RESERVED_SCRATCH, 8'h11);
      rd_none(base | 16'h0001);
      config_mode <= 1'b1;
      reg_rd(IDX_RESERVED_SCRATCH, 8'hC3);
      for (int n = 0; n < 4; n++)
      begin
         reg_wr(IDX_LOGICAL_DEVICE_SELECT, 8'(n));
         reg_wr(IDX_ACTIVATE, 8'h01);
      end
      reg_wr(IDX_LOGICAL_DEVICE_SELECT, 8'h01);
      reg_wr(IDX_ACTIVATE, 8'h00);
      #1;
      check(device_active, 16'h000D);
      reg_rd(IDX_LOGICAL_DEVICE_SELECT, 8'h01);
      check({8'h00, logical_device_sel}, 16'h0001);
      reg_wr(IDX_CLOCK_SOURCE_CONTROL, 8'h46);
      u_config_host.wr(base, IDX_CONFIG_CONTROL);
      u_config_host.wr(base | 16'h0001, 8'h01);
      pulses = 0;
      repeat (4)
      begin
         #1;
         pulses += int'(soft_reset_pulse === 1'b1);
         @(posedge clk);
      end
      check(16'(pulses), 16'h0001);
      reg_rd(IDX_CONFIG_CONTROL, 8'h00);
      reg_rd(IDX_LOGICAL_DEVICE_SELECT, 8'h00);
      reg_rd(IDX_FUNCTION_POWER_CONTROL, 8'h00);
      check(device_active, 16'h0000);
      reg_rd(IDX_RESERVED_SCRATCH, 8'hC3);
      reg_rd(IDX_CLOCK_SOURCE_CONTROL, 8'h46);
      check(config_port_addr, base);
      reg_wr(IDX_CONFIG_PORT_ADDR_LOW, 8'h4F);
      #1;
      check(config_port_addr, base);
      reg_rd(IDX_CONFIG_PORT_ADDR_LOW, 8'h4E);
      reg_wr(IDX_CONFIG_PORT_ADDR_HIGH, 8'h0A);
      #1;
      check(config_port_addr, 16'h0A4E);
      rd_none(base | 16'h0001);
      base = 16'h0A4E;
      reg_rd(IDX_CONFIG_PORT_ADDR_HIGH, 8'h0A);
      for (int s = 3; s >= 0; s--)
      begin
         bus_reset(2'(s));
         check(config_port_addr, strap_addr[s]);
      end
      base = STRAP_ADDR_00;
      reg_rd(IDX_CLOCK_SOURCE_CONTROL, 8'h44);
      results();
   end
endmodule : test_global_config_register_bank
